// File: hw/cos_clock_output.sv
// Output rate select, low-rate shaping, loop state machine, calibration
//
// Summary of operation
// (R1) Secondary out rate: off, 2k, 8k, synth b, synth a, main/aux taps.
// (R2) Primary out same coding, but 0011 is main/2 and 0101 main/1.
// (R3) Synth a rate from 2-bit code and line-standard bit, eight rates.
// (R4) Synth b chosen independently with its own code and standard bit.
// (R5) Frame pulses from main loop; 2k/8k clock options from chosen loop.
// (R6) Each 2k or 8k output is clock or pulse, optionally inverted.
// (R7) Pulse width is one period of secondary out; software sets it fast.
// (R8) Two-bit control group shapes 2k primary and multiframe outputs.
// (R9) Frame and multiframe pulse outputs each have an enable bit.
// (R10) Free-run timing comes from the local oscillator, unsynchronised.
// (R11) Automatic control after reset; forced control commands the state.
// (R12) Free-run to pre-locked on selection; 100 s timeout back to free-run.
// (R13) Locked after one second of continuous phase lock from trial states.
// (R14) Lost-phase on lock loss; serious bucket anomaly disqualifies reference.
// (R15) Over 100 s in lost-phase disqualifies reference and raises alarm.
// (R16) After disqualification: pre-locked2 with good stand-by, else holdover.
// (R17) Holdover when reference invalid and no replacement available.
// (R18) Holdover freezes loop frequency at its value on entry.
// (R19) Holdover to pre-locked2 on selection, or revertive higher restore; the code takes the revertive path from locked only.
// (R20) Pre-locked2 not locked within 100 s returns to holdover, reselects.
// (R21) Main loop state readable as a 3-bit status field.
// (R22) Aux loop is automatic, starts in zero-offset holdover, else locked.
// (R23) 16-bit calibration, default 9999 hex meaning zero offset.
// (R24) Every state change raises a state change event.
// (R25) Six states carry distinct 3-bit codes for status and forcing.
`default_nettype none

module cos_clock_output #(
	parameter longint LOCK_QUAL_CYCLES   = cos_pkg::LOCK_QUAL_CYC,
	parameter longint TRIAL_LIMIT_CYCLES = cos_pkg::TRIAL_LIMIT_CYC
) (
	input  wire logic        clock,
	input  wire logic        resetn,
	// Register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [7:0]  regRdData,
	// Clock taps from pins
	input  wire logic [7:0]  mainMulTaps,
	input  wire logic [4:0]  auxMulTaps,
	input  wire logic [7:0]  synthTaps,
	input  wire logic        main8k,
	input  wire logic        main2k,
	input  wire logic        aux8k,
	input  wire logic        aux2k,
	// Loop status from detectors and selection logic
	input  wire logic        refSelected,
	input  wire logic        phaseLocked,
	input  wire logic        bucketSerious,
	input  wire logic        standbyGood,
	input  wire logic        refInvalid,
	input  wire logic        revertive,
	input  wire logic        higherRestored,
	input  wire logic        auxPhaseLocked,
	// Outputs
	output logic             primaryClockOut,
	output logic             secondaryClockOut,
	output logic             framePulseOut,
	output logic             multiframePulseOut,
	output logic      [2:0]  mainLoopState,
	output logic             stateChangeEvent,
	output logic             refDisqualify,
	output logic             phaseAlarm,
	output logic             reselectRequest,
	output logic             useLocalOsc,
	output logic             holdoverFreeze,
	output logic             auxLoopLocked,
	output logic      [15:0] oscCalibration
);

	localparam int NPIN = 8 + 5 + 8 + 4;

	// ----------
	// Pin synchronisers
	// ----------
	logic [NPIN-1:0] pinMeta;
	logic [NPIN-1:0] pinSync;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			pinMeta <= '0;
			pinSync <= '0;
		end else begin
			pinMeta <= {mainMulTaps, auxMulTaps, synthTaps,
			            main8k, main2k, aux8k, aux2k};
			pinSync <= pinMeta;
		end
	end

	logic [7:0] mainTap;
	logic [4:0] auxTap;
	logic [7:0] synthTap;
	logic       m8k;
	logic       m2k;
	logic       a8k;
	logic       a2k;

	assign {mainTap, auxTap, synthTap, m8k, m2k, a8k, a2k} = pinSync;

	// ----------
	// Registers
	// ----------
	logic [7:0] synthStandard;
	logic [7:0] synthCode;
	logic [7:0] calLow;
	logic [7:0] calHigh;
	logic [7:0] secondaryRate;
	logic [7:0] primaryRate;
	logic [7:0] frameEnables;
	logic [7:0] lowRateShape;
	logic [7:0] forcedState;
	cos_pkg::cos_state_t state;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			synthStandard <= cos_pkg::RST_ZERO;
			synthCode     <= cos_pkg::RST_ZERO;
			calLow        <= cos_pkg::RST_CAL_LOW; // R23
			calHigh       <= cos_pkg::RST_CAL_HIGH; // R23
			secondaryRate <= cos_pkg::RST_ZERO;
			primaryRate   <= cos_pkg::RST_ZERO;
			frameEnables  <= cos_pkg::RST_FRAME_ENABLES;
			lowRateShape  <= cos_pkg::RST_ZERO;
			forcedState   <= cos_pkg::RST_ZERO; // R11
		end else if (regWrite) begin
			case (regAddr)
				cos_pkg::ADDR_SYNTH_STANDARD: synthStandard <= regWrData;
				cos_pkg::ADDR_SYNTH_CODE:     synthCode     <= regWrData;
				cos_pkg::ADDR_CAL_LOW:        calLow        <= regWrData;
				cos_pkg::ADDR_CAL_HIGH:       calHigh       <= regWrData;
				cos_pkg::ADDR_SECONDARY_RATE: secondaryRate <= regWrData;
				cos_pkg::ADDR_PRIMARY_RATE:   primaryRate   <= regWrData;
				cos_pkg::ADDR_FRAME_ENABLES:  frameEnables  <= regWrData;
				cos_pkg::ADDR_LOW_RATE_SHAPE: lowRateShape  <= regWrData;
				cos_pkg::ADDR_FORCED_STATE:   forcedState   <= regWrData;
				default: ;
			endcase
		end
	end

	logic [7:0] next_regRdData;

	always_comb begin
		case (regAddr)
			cos_pkg::ADDR_LOOP_STATE:
				next_regRdData = {5'h00, state}; // R21
			cos_pkg::ADDR_SYNTH_STANDARD: next_regRdData = synthStandard;
			cos_pkg::ADDR_SYNTH_CODE:     next_regRdData = synthCode;
			cos_pkg::ADDR_CAL_LOW:        next_regRdData = calLow;
			cos_pkg::ADDR_CAL_HIGH:       next_regRdData = calHigh;
			cos_pkg::ADDR_SECONDARY_RATE: next_regRdData = secondaryRate;
			cos_pkg::ADDR_PRIMARY_RATE:   next_regRdData = primaryRate;
			cos_pkg::ADDR_FRAME_ENABLES:  next_regRdData = frameEnables;
			cos_pkg::ADDR_LOW_RATE_SHAPE: next_regRdData = lowRateShape;
			cos_pkg::ADDR_FORCED_STATE:   next_regRdData = forcedState;
			default:                      next_regRdData = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			regRdData <= 8'h00;
		else if (regRead)
			regRdData <= next_regRdData;
	end

	assign oscCalibration = {calHigh, calLow}; // R23

	// ----------
	// Synth rate selection
	// ----------
	logic synthA;
	logic synthB;

	assign synthA = synthTap[{synthStandard[cos_pkg::STD_A_BIT],
	                 synthCode[cos_pkg::CODE_A_LSB +: 2]}]; // R3
	assign synthB = synthTap[{synthStandard[cos_pkg::STD_B_BIT],
	                 synthCode[cos_pkg::CODE_B_LSB +: 2]}]; // R4

	// ----------
	// Low-rate shaping
	// ----------
	logic       loopSelAux;
	logic [3:0] lowRateIn;
	logic [3:0] lowRateOut;
	logic [3:0] isTwoK;

	assign loopSelAux = lowRateShape[cos_pkg::LOOP_SEL_BIT];
	// 0 frame, 1 multiframe, 2 port 8k, 3 port 2k
	assign lowRateIn = {loopSelAux ? a2k : m2k,
	                    loopSelAux ? a8k : m8k, // R5
	                    m2k, m8k}; // R5
	assign isTwoK = 4'hA;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_shape
			logic [1:0] ctl;
			assign ctl = isTwoK[gi]
				? lowRateShape[cos_pkg::SHAPE_2K_LSB +: 2] // R8
				: lowRateShape[cos_pkg::SHAPE_8K_LSB +: 2];
			cos_shaper u_shape (
				.clock      (clock),
				.resetn     (resetn),
				.rateLevel  (lowRateIn[gi]),
				.widthLevel (secondaryClockOut), // R7
				.pulseMode  (ctl[0]),
				.invert     (ctl[1]),
				.shaped     (lowRateOut[gi])
			);
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (!resetn) begin
			framePulseOut      <= 1'b0;
			multiframePulseOut <= 1'b0;
		end else begin
			framePulseOut      <= lowRateOut[0] &
				frameEnables[cos_pkg::FRAME_EN_BIT]; // R9
			multiframePulseOut <= lowRateOut[1] &
				frameEnables[cos_pkg::MFRAME_EN_BIT]; // R9
		end
	end

	// ----------
	// Port rate muxes
	// ----------
	function automatic logic rateMux(input logic [3:0] code,
	                                 input logic primary,
	                                 input logic [7:0] mt,
	                                 input logic [4:0] at,
	                                 input logic l2k, input logic l8k,
	                                 input logic sa, input logic sb);
		case (code)
			cos_pkg::RATE_OFF:     rateMux = 1'b0;
			cos_pkg::RATE_2K:      rateMux = l2k;
			cos_pkg::RATE_8K:      rateMux = l8k;
			cos_pkg::RATE_SYNTH_B:
				rateMux = primary ? mt[cos_pkg::TAP_M2] : sb; // R2
			cos_pkg::RATE_SYNTH_A: rateMux = sa;
			cos_pkg::RATE_MAIN_LO:
				rateMux = primary ? mt[cos_pkg::TAP_M1] // R2
				                  : mt[cos_pkg::TAP_M48];
			4'h6: rateMux = mt[cos_pkg::TAP_M16];
			4'h7: rateMux = mt[cos_pkg::TAP_M12];
			4'h8: rateMux = mt[cos_pkg::TAP_M8];
			4'h9: rateMux = mt[cos_pkg::TAP_M6];
			4'hA: rateMux = mt[cos_pkg::TAP_M4];
			4'hB: rateMux = at[cos_pkg::TAP_A64];
			4'hC: rateMux = at[cos_pkg::TAP_A48];
			4'hD: rateMux = at[cos_pkg::TAP_A16];
			4'hE: rateMux = at[cos_pkg::TAP_A8];
			default: rateMux = at[cos_pkg::TAP_A4];
		endcase
	endfunction : rateMux

	always_ff @(posedge clock) begin
		if (!resetn) begin
			secondaryClockOut <= 1'b0;
			primaryClockOut   <= 1'b0;
		end else begin
			secondaryClockOut <= rateMux(
				secondaryRate[cos_pkg::SECONDARY_LSB +: 4], 1'b0,
				mainTap, auxTap, lowRateOut[3], lowRateOut[2],
				synthA, synthB); // R1
			primaryClockOut <= rateMux(
				primaryRate[cos_pkg::PRIMARY_LSB +: 4], 1'b1,
				mainTap, auxTap, lowRateOut[3], lowRateOut[2],
				synthA, synthB); // R2
		end
	end

	// ----------
	// Main loop state machine
	// ----------
	cos_pkg::cos_state_t next_state;
	logic lockQualified;
	logic trialExpired;
	logic inTrial;
	logic stateMoves;
	logic forceOn;
	logic next_disqualify;
	logic next_alarm;
	logic next_reselect;

	assign inTrial = (state == cos_pkg::ST_PRE_LOCKED)
	              || (state == cos_pkg::ST_PRE_LOCKED2)
	              || (state == cos_pkg::ST_LOST_PHASE);
	assign stateMoves = (next_state != state);
	assign forceOn = forcedState[cos_pkg::FORCE_EN_BIT];

	cos_timer #(.COUNT(LOCK_QUAL_CYCLES)) u_lockTimer (
		.clock   (clock),
		.resetn  (resetn),
		.clear   (stateMoves),
		.run     (inTrial & phaseLocked), // R13
		.expired (lockQualified)
	);

	cos_timer #(.COUNT(TRIAL_LIMIT_CYCLES)) u_trialTimer (
		.clock   (clock),
		.resetn  (resetn),
		.clear   (stateMoves),
		.run     (inTrial),
		.expired (trialExpired)
	);

	always_comb begin
		next_state      = state;
		next_disqualify = 1'b0;
		next_alarm      = 1'b0;
		next_reselect   = 1'b0;
		if (forceOn) begin
			if (forcedState[2:0] <= 3'h5) // R25
				next_state = cos_pkg::cos_state_t'(forcedState[2:0]); // R11
		end else begin
			case (state)
				cos_pkg::ST_FREE_RUN:
					if (refSelected)
						next_state = cos_pkg::ST_PRE_LOCKED; // R12
				cos_pkg::ST_PRE_LOCKED:
					if (lockQualified)
						next_state = cos_pkg::ST_LOCKED; // R13
					else if (trialExpired) begin
						next_state    = cos_pkg::ST_FREE_RUN; // R12
						next_reselect = 1'b1; // R12
					end
				cos_pkg::ST_LOCKED:
					if (refInvalid && !standbyGood)
						next_state = cos_pkg::ST_HOLDOVER; // R17
					else if (!phaseLocked)
						next_state = cos_pkg::ST_LOST_PHASE; // R14
					else if (revertive && higherRestored)
						next_state = cos_pkg::ST_PRE_LOCKED2; // R19
				cos_pkg::ST_LOST_PHASE:
					if (lockQualified)
						next_state = cos_pkg::ST_LOCKED; // R13
					else if (bucketSerious || trialExpired
					         || refInvalid) begin
						next_disqualify = 1'b1; // R14
						next_alarm      = trialExpired; // R15
						next_state = standbyGood
							? cos_pkg::ST_PRE_LOCKED2 // R16
							: cos_pkg::ST_HOLDOVER; // R16
					end
				cos_pkg::ST_HOLDOVER:
					if (refSelected)
						next_state = cos_pkg::ST_PRE_LOCKED2; // R19
				cos_pkg::ST_PRE_LOCKED2:
					if (lockQualified)
						next_state = cos_pkg::ST_LOCKED; // R13
					else if (trialExpired) begin
						next_state    = cos_pkg::ST_HOLDOVER; // R20
						next_reselect = 1'b1; // R20
					end
				default: next_state = cos_pkg::ST_FREE_RUN;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			state <= cos_pkg::ST_FREE_RUN; // R11
		else
			state <= next_state;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			stateChangeEvent <= 1'b0;
			refDisqualify    <= 1'b0;
			phaseAlarm       <= 1'b0;
			reselectRequest  <= 1'b0;
		end else begin
			stateChangeEvent <= stateMoves; // R24
			refDisqualify    <= next_disqualify;
			phaseAlarm       <= next_alarm;
			reselectRequest  <= next_reselect;
		end
	end

	assign mainLoopState  = state; // R21
	assign useLocalOsc    = (state == cos_pkg::ST_FREE_RUN); // R10
	assign holdoverFreeze = (state == cos_pkg::ST_HOLDOVER); // R18

	// ----------
	// Aux loop: holdover at start-up, locked when its detector agrees
	// ----------
	always_ff @(posedge clock) begin
		if (!resetn)
			auxLoopLocked <= 1'b0; // R22
		else
			auxLoopLocked <= auxPhaseLocked; // R22
	end

endmodule : cos_clock_output

`default_nettype wire

// File: hw/cos_pkg.sv
// Constants, register map and state type for the clock output block
`default_nettype none

package cos_pkg;

	// ----------
	// Register offsets
	// ----------
	localparam logic [7:0] ADDR_LOOP_STATE     = 8'h09;
	localparam logic [7:0] ADDR_FORCED_STATE   = 8'h4A;
	localparam logic [7:0] ADDR_SYNTH_STANDARD = 8'h38;
	localparam logic [7:0] ADDR_SYNTH_CODE     = 8'h39;
	localparam logic [7:0] ADDR_CAL_LOW        = 8'h3C;
	localparam logic [7:0] ADDR_CAL_HIGH       = 8'h3D;
	localparam logic [7:0] ADDR_SECONDARY_RATE = 8'h61;
	localparam logic [7:0] ADDR_PRIMARY_RATE   = 8'h62;
	localparam logic [7:0] ADDR_FRAME_ENABLES  = 8'h63;
	localparam logic [7:0] ADDR_LOW_RATE_SHAPE = 8'h7A;

	// ----------
	// Reset values
	// ----------
	localparam logic [7:0] RST_CAL_LOW       = 8'h99;
	localparam logic [7:0] RST_CAL_HIGH      = 8'h99;
	localparam logic [7:0] RST_FRAME_ENABLES = 8'hC0;
	localparam logic [7:0] RST_ZERO          = 8'h00;

	// ----------
	// Field positions
	// ----------
	localparam int STD_A_BIT      = 5;
	localparam int STD_B_BIT      = 6;
	localparam int CODE_A_LSB     = 4;
	localparam int CODE_B_LSB     = 6;
	localparam int SECONDARY_LSB  = 0;
	localparam int PRIMARY_LSB    = 4;
	localparam int FRAME_EN_BIT   = 7;
	localparam int MFRAME_EN_BIT  = 6;
	localparam int LOOP_SEL_BIT   = 7;
	localparam int SHAPE_2K_LSB   = 0;
	localparam int SHAPE_8K_LSB   = 2;
	localparam int FORCE_EN_BIT   = 3;

	// ----------
	// Rate select codes
	// ----------
	localparam logic [3:0] RATE_OFF     = 4'h0;
	localparam logic [3:0] RATE_2K      = 4'h1;
	localparam logic [3:0] RATE_8K      = 4'h2;
	localparam logic [3:0] RATE_SYNTH_B = 4'h3;
	localparam logic [3:0] RATE_SYNTH_A = 4'h4;
	localparam logic [3:0] RATE_MAIN_LO = 4'h5;

	// Main multiplier taps: /1 /2 /4 /6 /8 /12 /16 /48
	localparam int MAIN_TAPS = 8;
	localparam int TAP_M1  = 0;
	localparam int TAP_M2  = 1;
	localparam int TAP_M4  = 2;
	localparam int TAP_M6  = 3;
	localparam int TAP_M8  = 4;
	localparam int TAP_M12 = 5;
	localparam int TAP_M16 = 6;
	localparam int TAP_M48 = 7;
	// Aux multiplier taps: /4 /8 /16 /48 /64
	localparam int AUX_TAPS = 5;
	localparam int TAP_A4  = 0;
	localparam int TAP_A8  = 1;
	localparam int TAP_A16 = 2;
	localparam int TAP_A48 = 3;
	localparam int TAP_A64 = 4;
	// Synth taps indexed by {line standard, 2-bit code}
	localparam int SYNTH_TAPS = 8;

	// ----------
	// Timing at 10 MHz
	// ----------
	localparam longint CLOCK_HZ       = 10000000;
	localparam longint LOCK_QUAL_S    = 1;
	localparam longint TRIAL_LIMIT_S  = 100;
	localparam longint LOCK_QUAL_CYC  = LOCK_QUAL_S * CLOCK_HZ;
	localparam longint TRIAL_LIMIT_CYC = TRIAL_LIMIT_S * CLOCK_HZ;

	typedef enum logic [2:0] {
		ST_FREE_RUN,
		ST_PRE_LOCKED,
		ST_LOCKED,
		ST_LOST_PHASE,
		ST_HOLDOVER,
		ST_PRE_LOCKED2
	} cos_state_t;

endpackage : cos_pkg

`default_nettype wire

// File: hw/cos_shaper.sv
// Low-rate clock or pulse shaper with optional inversion
`default_nettype none

module cos_shaper (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic rateLevel,
	input  wire logic widthLevel,
	input  wire logic pulseMode,
	input  wire logic invert,
	output logic      shaped
);

	logic prevRate;
	logic prevWidth;
	logic pulseActive;
	logic rateFall;
	logic widthFall;

	assign rateFall  = prevRate & ~rateLevel;
	assign widthFall = prevWidth & ~widthLevel;

	always_ff @(posedge clock) begin
		if (!resetn) begin
			prevRate  <= 1'b0;
			prevWidth <= 1'b0;
		end else begin
			prevRate  <= rateLevel;
			prevWidth <= widthLevel;
		end
	end

	// Pulse opens on the low-rate falling edge, closes one width period on
	always_ff @(posedge clock) begin
		if (!resetn)
			pulseActive <= 1'b0;
		else if (rateFall)
			pulseActive <= 1'b1; // R7
		else if (widthFall)
			pulseActive <= 1'b0; // R7
	end

	always_ff @(posedge clock) begin
		if (!resetn)
			shaped <= 1'b0;
		else
			shaped <= (pulseMode ? pulseActive : rateLevel) ^ invert; // R6
	end

endmodule : cos_shaper

`default_nettype wire

// File: hw/cos_timer.sv
// Saturating interval timer with synchronous clear
`default_nettype none

module cos_timer #(
	parameter longint COUNT = 10
) (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic clear,
	input  wire logic run,
	output logic      expired
);

	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LAST = W'(COUNT);
	localparam logic [W-1:0] ONE  = W'(1);

	logic [W-1:0] count;

	always_ff @(posedge clock) begin
		if (!resetn)
			count <= '0;
		else if (clear || !run)
			count <= '0;
		else if (count != LAST)
			count <= count + ONE;
	end

	assign expired = (count == LAST);

endmodule : cos_timer

`default_nettype wire

// File: sim/cos_card_model.sv
// Clock card model: tap levels and loop status after a clock edge
`default_nettype none

module cos_card_model (
	input  wire logic        clock,
	input  wire logic [24:0] pattern,
	input  wire logic [7:0]  status,
	output logic      [24:0] tapLevels,
	output logic      [7:0]  loopStatus
);
	always_ff @(posedge clock) begin
		tapLevels <= pattern;
	end
	always_ff @(posedge clock) begin
		loopStatus <= status;
	end
endmodule : cos_card_model

`default_nettype wire

// File: sim/cos_clock_output_sva.sv
// Port checks for the clock output block
`default_nettype none

module cos_clock_output_sva #(
	parameter longint LOCK_QUAL_CYCLES = 20
) (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic [7:0]  regAddr,
	input wire logic [7:0]  regWrData,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [7:0]  regRdData,
	input wire logic        refSelected,
	input wire logic        phaseLocked,
	input wire logic        standbyGood,
	input wire logic        refInvalid,
	input wire logic        framePulseOut,
	input wire logic [2:0]  mainLoopState,
	input wire logic        stateChangeEvent,
	input wire logic        useLocalOsc,
	input wire logic        holdoverFreeze,
	input wire logic [15:0] oscCalibration
);
	logic        forced;
	logic        frameOn;
	logic [31:0] lockRun;

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// ----------
	// Shadow state
	// ----------
	always_ff @(posedge clock) begin
		if (!resetn || !phaseLocked)
			lockRun <= 32'h0;
		else
			lockRun <= lockRun + 32'h1;
	end
	always_ff @(posedge clock) begin
		if (!resetn)
			forced <= 1'b0;
		else if (regWrite && regAddr == cos_pkg::ADDR_FORCED_STATE)
			forced <= regWrData[cos_pkg::FORCE_EN_BIT];
	end
	always_ff @(posedge clock) begin
		if (!resetn)
			frameOn <= 1'b1;
		else if (regWrite && regAddr == cos_pkg::ADDR_FRAME_ENABLES)
			frameOn <= regWrData[cos_pkg::FRAME_EN_BIT];
	end

	sequence s_frame_off;
		!frameOn [*4];
	endsequence
	sequence s_auto_locked;
		!forced && mainLoopState == cos_pkg::ST_LOCKED;
	endsequence

	// ----------
	// Assertions
	// ----------
	a_status_read: assert property (regRead &&
		regAddr == cos_pkg::ADDR_LOOP_STATE |=>
		regRdData == {5'h00, $past(mainLoopState)})
		else $error("readback");
	a_free_local: assert property (useLocalOsc ==
		(mainLoopState == cos_pkg::ST_FREE_RUN))
		else $error("local osc flag");
	a_hold_freeze: assert property (holdoverFreeze ==
		(mainLoopState == cos_pkg::ST_HOLDOVER))
		else $error("freeze flag");
	a_event_pulse: assert property ($changed(mainLoopState)
		|-> stateChangeEvent)
		else $error("no event");
	a_auto_prelock: assert property (!forced && refSelected &&
		mainLoopState == cos_pkg::ST_FREE_RUN |=>
		mainLoopState == cos_pkg::ST_PRE_LOCKED)
		else $error("no pre-lock");
	a_lock_qual: assert property ($changed(mainLoopState) &&
		mainLoopState == cos_pkg::ST_LOCKED && !$past(forced)
		|-> lockRun >= LOCK_QUAL_CYCLES)
		else $error("early lock");
	a_lose_phase: assert property (s_auto_locked and
		(!phaseLocked && !refInvalid) |=>
		mainLoopState == cos_pkg::ST_LOST_PHASE)
		else $error("no lost-phase");
	a_hold_entry: assert property (s_auto_locked and
		(refInvalid && !standbyGood) |=>
		mainLoopState == cos_pkg::ST_HOLDOVER)
		else $error("no holdover");
	a_cal_low: assert property (regWrite &&
		regAddr == cos_pkg::ADDR_CAL_LOW |=>
		oscCalibration[7:0] == $past(regWrData))
		else $error("cal low byte");
	a_frame_gate: assert property (s_frame_off |->
		!framePulseOut)
		else $error("frame not gated");
endmodule : cos_clock_output_sva

bind cos_clock_output cos_clock_output_sva #(
	.LOCK_QUAL_CYCLES(LOCK_QUAL_CYCLES)
) u_sva (
	.clock(clock), .resetn(resetn), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
	.regRdData(regRdData), .refSelected(refSelected),
	.phaseLocked(phaseLocked), .standbyGood(standbyGood),
	.refInvalid(refInvalid), .framePulseOut(framePulseOut),
	.mainLoopState(mainLoopState), .stateChangeEvent(stateChangeEvent),
	.useLocalOsc(useLocalOsc), .holdoverFreeze(holdoverFreeze),
	.oscCalibration(oscCalibration)
);

`default_nettype wire

// File: sim/testbench.sv
// Self-checking testbench for the clock output block
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock     = 1'b0;
	logic        resetn    = 1'b0;
	logic [7:0]  regAddr   = 8'h00;
	logic [7:0]  regWrData = 8'h00;
	logic        regWrite  = 1'b0;
	logic        regRead   = 1'b0;
	logic [24:0] pat       = 25'h0;
	logic [7:0]  st        = 8'h00;
	logic [31:0] rnd       = 32'h00010FF8;
	logic [7:0]  regRdData, shp, stdSel, codSel, stIn;
	logic [24:0] taps;
	logic [15:0] cal;
	logic [2:0]  loopState;
	logic        priOut, secOut, frmOut, mfrOut, auxLock, frz, dq, alm, rsl;
	int          failures  = 0;
	int          cmpCount  = 0;
	int          cycles    = 0;
	logic [7:0]  rwRegs[8] = '{8'h38, 8'h39, 8'h3C, 8'h3D, 8'h61, 8'h62,
		8'h63, 8'h7A};

	cos_card_model u_card (.clock(clock), .pattern(pat), .status(st),
		.tapLevels(taps), .loopStatus(stIn));

	cos_clock_output #(.LOCK_QUAL_CYCLES(20), .TRIAL_LIMIT_CYCLES(100)) u_dut (
		.clock(clock), .resetn(resetn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .mainMulTaps(taps[7:0]),
		.auxMulTaps(taps[12:8]), .synthTaps(taps[20:13]),
		.main8k(taps[21]), .main2k(taps[22]), .aux8k(taps[23]),
		.aux2k(taps[24]), .refSelected(stIn[7]), .phaseLocked(stIn[6]),
		.bucketSerious(stIn[5]), .standbyGood(stIn[4]),
		.refInvalid(stIn[3]), .revertive(stIn[2]),
		.higherRestored(stIn[1]), .auxPhaseLocked(stIn[0]),
		.primaryClockOut(priOut), .secondaryClockOut(secOut),
		.framePulseOut(frmOut), .multiframePulseOut(mfrOut),
		.mainLoopState(loopState), .stateChangeEvent(),
		.refDisqualify(dq), .phaseAlarm(alm), .reselectRequest(rsl),
		.useLocalOsc(), .holdoverFreeze(frz), .auxLoopLocked(auxLock),
		.oscCalibration(cal));

	always #50 clock = ~clock;

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// Expected port level for a rate code
	function automatic logic expRate(input logic [3:0] c, input logic pri);
		case (c)
			4'h0: return 1'b0;
			4'h1: return (shp[7] ? pat[24] : pat[22]) ^ shp[1];
			4'h2: return (shp[7] ? pat[23] : pat[21]) ^ shp[3];
			4'h3: return pri ? pat[1] : pat[13 + {stdSel[6], codSel[7:6]}];
			4'h4: return pat[13 + {stdSel[5], codSel[5:4]}];
			4'h5: return pri ? pat[0] : pat[7];
			default: return c > 4'hA ? pat[23 - c] : pat[12 - c];
		endcase
	endfunction : expRate

	task automatic chk(input string what, input logic [15:0] got, exp);
		cmpCount++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, d);
		@(posedge clock);
		regAddr   <= a;
		regWrData <= d;
		regWrite  <= 1'b1;
		@(posedge clock);
		regWrite  <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		chk("read data", regRdData, exp);
	endtask : rd

	task automatic go(input logic [7:0] v);
		@(posedge clock);
		st <= v;
	endtask : go

	task automatic waitSt(input logic [2:0] s, input int lim, output int n);
		n = 0;
		while (loopState !== s && n < lim) begin
			@(negedge clock);
			n++;
		end
		chk("loop state", loopState, s);
	endtask : waitSt

	task automatic close_out();
		$display("Checks %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		int n;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		rd(cos_pkg::ADDR_CAL_LOW, cos_pkg::RST_CAL_LOW);
		rd(cos_pkg::ADDR_CAL_HIGH, cos_pkg::RST_CAL_HIGH);
		rd(cos_pkg::ADDR_FRAME_ENABLES, cos_pkg::RST_FRAME_ENABLES);
		chk("calibration", cal, 16'h9999);
		foreach (rwRegs[i]) begin
			rnd = lfsr(rnd);
			wr(rwRegs[i], rnd[7:0]);
			rd(rwRegs[i], rnd[7:0]);
		end
		wr(cos_pkg::ADDR_LOOP_STATE, 8'hFF);
		rd(cos_pkg::ADDR_LOOP_STATE, 8'h00);
		rd(8'hFF, 8'h00);
		// Random tap levels through every rate code, clock mode
		for (int i = 0; i < 48; i++) begin
			@(posedge clock);
			rnd = lfsr(rnd);
			pat <= rnd[24:0];
			shp = rnd[31:24] & 8'h8A;
			rnd = lfsr(rnd);
			stdSel = rnd[7:0];
			codSel = rnd[15:8];
			wr(cos_pkg::ADDR_SYNTH_STANDARD, stdSel);
			wr(cos_pkg::ADDR_SYNTH_CODE, codSel);
			wr(cos_pkg::ADDR_LOW_RATE_SHAPE, shp);
			wr(cos_pkg::ADDR_FRAME_ENABLES, rnd[23:16]);
			wr(cos_pkg::ADDR_SECONDARY_RATE, {4'h0, i[3:0]});
			wr(cos_pkg::ADDR_PRIMARY_RATE, {rnd[27:24], 4'h0});
			st <= {7'h00, rnd[28]};
			repeat (6) @(posedge clock);
			@(negedge clock);
			chk("secondary", secOut, expRate(i[3:0], 1'b0));
			chk("primary", priOut, expRate(rnd[27:24], 1'b1));
			chk("frame", frmOut, rnd[23] & (pat[21] ^ shp[3]));
			chk("multiframe", mfrOut, rnd[22] & (pat[22] ^ shp[1]));
			chk("aux lock", auxLock, rnd[28]);
		end
		go(8'h80);
		waitSt(3'h1, 5, n);
		go(8'h00);
		waitSt(3'h0, 130, n);
		chk("trial span", n > 90, 1'b1);
		chk("reselect", rsl, 1'b1);
		go(8'hC0);
		waitSt(3'h2, 60, n);
		chk("lock span", n > 18, 1'b1);
		go(8'h80);
		waitSt(3'h3, 5, n);
		go(8'hB0);
		waitSt(3'h5, 5, n);
		chk("disqualify", dq, 1'b1);
		go(8'hC0);
		waitSt(3'h2, 60, n);
		go(8'hC6);
		waitSt(3'h5, 5, n);
		go(8'hC0);
		waitSt(3'h2, 60, n);
		go(8'h00);
		waitSt(3'h3, 5, n);
		waitSt(3'h4, 130, n);
		chk("lost span", n > 90, 1'b1);
		chk("alarm", alm, 1'b1);
		chk("freeze", frz, 1'b1);
		go(8'h80);
		waitSt(3'h5, 5, n);
		go(8'h00);
		waitSt(3'h4, 130, n);
		chk("retry span", n > 90, 1'b1);
		chk("reselect", rsl, 1'b1);
		go(8'hC0);
		waitSt(3'h2, 60, n);
		go(8'h48);
		waitSt(3'h4, 5, n);
		rd(cos_pkg::ADDR_LOOP_STATE, 8'h04);
		for (int k = 0; k < 6; k++) begin
			wr(cos_pkg::ADDR_FORCED_STATE, 8'h08 | k[7:0]);
			waitSt(k[2:0], 4, n);
		end
		wr(cos_pkg::ADDR_FORCED_STATE, 8'h0E);
		repeat (3) @(posedge clock);
		chk("forced code six", loopState, 3'h5);
		close_out();
	end
endmodule : testbench

`default_nettype wire
